// file: hdl/cotf_pkg.sv
package cotf_pkg;

  localparam logic [7:0] ADDR_STATUS      = 8'hD0;
  localparam logic [7:0] ADDR_ACCUM       = 8'hE0;
  localparam logic [7:0] ADDR_OPCODE      = 8'h00;
  localparam logic [7:0] ADDR_OPERAND     = 8'h04;
  localparam logic [7:0] ADDR_PC          = 8'h08;
  localparam logic [7:0] ADDR_DECODE      = 8'h0C;
  localparam logic [7:0] ADDR_TARGET      = 8'h10;
  localparam logic [7:0] ADDR_ALU         = 8'h14;
  localparam logic [7:0] ADDR_RAM         = 8'h18;

  localparam int CY_BIT = 7;
  localparam int AC_BIT = 6;
  localparam int F0_BIT = 5;
  localparam int RS1_BIT = 4;
  localparam int RS0_BIT = 3;
  localparam int OV_BIT = 2;
  localparam int F1_BIT = 1;
  localparam int P_BIT = 0;
  localparam logic [7:0] USER_MASK        = 8'h3A;
  localparam logic [7:0] STATUS_RESET     = 8'h00;
  localparam logic [7:0] ACCUM_RESET      = 8'h00;
  localparam logic [3:0] BANK_SIZE        = 4'h8;

  localparam int CLK_HZ = 20_000_000;
  localparam int OSC_PER_MACHINE = 12;
  localparam logic [4:0] CLOCKS_SHORT     = 5'h0C;
  localparam logic [4:0] CLOCKS_LONG      = 5'h18;

  localparam logic [4:0] ACALL_LOW        = 5'h11;
  localparam logic [4:0] AJMP_LOW         = 5'h01;

  typedef enum logic [2:0] {
    COTF_OP_NONE, COTF_OP_XOR, COTF_OP_ACC, COTF_OP_MOV,
    COTF_OP_XCH, COTF_OP_BIT, COTF_OP_FLOW
  } cotf_class_t;

endpackage : cotf_pkg

// file: hdl/cotf_ram.sv
`timescale 1ns/1ps
`default_nettype none
module cotf_ram #(
  parameter int AW = 5
) (
  // Clock
  input  wire logic          mclk,
  // Write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // Read side
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk)
  begin
    rdata <= mem[raddr];
  end
endmodule : cotf_ram
`default_nettype wire

// file: hdl/cotf_core.sv
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module cotf_core (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Status
  output logic             busy,
  output logic      [7:0]  status_flags
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [2:0] op_bytes(input logic [7:0] op);
    logic [2:0] n;
    n = 3'h1;
    if (op[4:0] == cotf_pkg::ACALL_LOW || op[4:0] == cotf_pkg::AJMP_LOW)
    begin
      n = 3'h2;
    end
    else
    begin
      case (op)
        8'h65, 8'h64, 8'h62: n = 3'h2;
        8'h63, 8'h43: n = 3'h3;
        8'hC5: n = 3'h2;
        8'hC2, 8'hD2, 8'hB2: n = 3'h2;
        8'h82, 8'hB0, 8'h72, 8'hA0: n = 3'h2;
        8'hA2, 8'h92: n = 3'h2;
        8'h12, 8'h02: n = 3'h3;
        8'h80, 8'h60, 8'h70, 8'h40, 8'h50: n = 3'h2;
        default: n = 3'h1;
      endcase
    end
    return n;
  endfunction : op_bytes

  function automatic logic op_long(input logic [7:0] op);
    logic l;
    l = 1'b0;
    if (op[4:0] == cotf_pkg::ACALL_LOW || op[4:0] == cotf_pkg::AJMP_LOW)
    begin
      l = 1'b1;
    end
    else
    begin
      case (op)
        8'h63, 8'h43: l = 1'b1;
        8'hC5: l = 1'b1;
        8'h82, 8'hB0, 8'h72, 8'hA0: l = 1'b1;
        8'h92: l = 1'b1;
        8'h12, 8'h02, 8'h22, 8'h32: l = 1'b1;
        8'h73, 8'h80, 8'h60, 8'h70, 8'h40, 8'h50: l = 1'b1;
        default: l = 1'b0;
      endcase
    end
    return l;
  endfunction : op_long

  function automatic cotf_pkg::cotf_class_t op_class(input logic [7:0] op);
    cotf_pkg::cotf_class_t c;
    c = cotf_pkg::COTF_OP_NONE;
    if (op[4:0] == cotf_pkg::ACALL_LOW || op[4:0] == cotf_pkg::AJMP_LOW)
    begin
      c = cotf_pkg::COTF_OP_FLOW;
    end
    else if (op[7:3] == 5'h0D || (op >= 8'h62 && op <= 8'h67))
    begin
      c = cotf_pkg::COTF_OP_XOR;
    end
    else if (op[7:3] == 5'h1D || op == 8'hE6 || op == 8'hE7)
    begin
      c = cotf_pkg::COTF_OP_MOV;
    end
    else
    begin
      case (op)
        8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4: c = cotf_pkg::COTF_OP_ACC;
        8'hC6, 8'hC7, 8'hD6, 8'hD7, 8'hC5: c = cotf_pkg::COTF_OP_XCH;
        8'hC3, 8'hD3, 8'hB3, 8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0,
        8'hA2, 8'h92: c = cotf_pkg::COTF_OP_BIT;
        8'h43: c = cotf_pkg::COTF_OP_XOR;
        8'h12, 8'h02, 8'h22, 8'h32, 8'h73, 8'h80, 8'h60, 8'h70, 8'h40,
        8'h50: c = cotf_pkg::COTF_OP_FLOW;
        default: c = cotf_pkg::COTF_OP_NONE;
      endcase
    end
    return c;
  endfunction : op_class

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  status_q;
  logic [7:0]  accum_q;
  logic [7:0]  opcode_q;
  logic [7:0]  operand_q;
  logic [15:0] pc_q;
  logic [15:0] target_q;
  logic [4:0]  clk_cnt_q;
  logic [4:0]  clk_len_q;
  logic        run_q;
  logic [1:0]  mcycles_q;
  logic        rd_pend_q;
  logic        rd_done_q;
  logic [7:0]  rd_addr_q;

  wire logic   wr_hit    = avs_write;
  wire logic [7:0] wbyte = avs_writedata[7:0];
  wire logic   parity    = ^accum_q;
  wire logic [1:0] bank  = status_q[cotf_pkg::RS1_BIT:cotf_pkg::RS0_BIT];
  wire logic [4:0] ram_waddr = {bank, avs_address[4:2]};
  wire logic [15:0] pc_next  = pc_q + {13'h0000, op_bytes(wbyte)};
  // The first cycle of a launch borrows the read port for the working register
  wire logic [4:0] ram_raddr = (run_q && clk_cnt_q == 5'h01) ? {bank, opcode_q[2:0]}
                               : ram_waddr;
  wire logic   ram_we    = avs_write && avs_address >= cotf_pkg::ADDR_RAM
                           && avs_address[7:5] == 3'h1;
  logic [7:0] ram_rdata;

  cotf_ram #(.AW(5)) u_ram (
    .mclk  (mclk),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (wbyte),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Instruction timing: 12 oscillator clocks per machine cycle

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      run_q        <= 1'b0;
      clk_cnt_q    <= 5'h00;
      clk_len_q    <= cotf_pkg::CLOCKS_SHORT;
      mcycles_q    <= 2'h0;
    end
    else if (wr_hit && avs_address == cotf_pkg::ADDR_OPCODE && !run_q)
    begin
      run_q     <= 1'b1;
      clk_cnt_q <= 5'h01;
      clk_len_q <= op_long(wbyte) ? cotf_pkg::CLOCKS_LONG : cotf_pkg::CLOCKS_SHORT;
      mcycles_q <= 2'h0;
    end
    else if (run_q)
    begin
      if (clk_cnt_q == cotf_pkg::CLOCKS_SHORT || clk_cnt_q == cotf_pkg::CLOCKS_LONG)
      begin
        mcycles_q <= mcycles_q + 2'h1;
      end
      if (clk_cnt_q == clk_len_q)
      begin
        run_q <= 1'b0;
      end
      clk_cnt_q <= clk_cnt_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction capture and branch target

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      opcode_q  <= 8'h00;
      operand_q <= 8'h00;
      pc_q      <= 16'h0000;
      target_q  <= 16'h0000;
    end
    else
    begin
      if (wr_hit && avs_address == cotf_pkg::ADDR_OPERAND)
      begin
        operand_q <= wbyte;
      end
      if (wr_hit && avs_address == cotf_pkg::ADDR_PC)
      begin
        pc_q <= avs_writedata[15:0];
      end
      if (wr_hit && avs_address == cotf_pkg::ADDR_OPCODE && !run_q)
      begin
        opcode_q <= wbyte;
        // Target uses the PC already past this instruction
        target_q <= {pc_next[15:11], wbyte[7:5], operand_q};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and ALU flag update

  logic [8:0] sum7;
  logic [4:0] sum4;
  logic [7:0] sum6;
  always_comb
  begin
    sum4 = {1'b0, accum_q[3:0]} + {1'b0, wbyte[3:0]};
    sum6 = {1'b0, accum_q[6:0]} + {1'b0, wbyte[6:0]};
    sum7 = {1'b0, accum_q} + {1'b0, wbyte};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      accum_q <= cotf_pkg::ACCUM_RESET;
    end
    else if (wr_hit && avs_address == cotf_pkg::ADDR_ACCUM)
    begin
      accum_q <= wbyte;
    end
    else if (wr_hit && avs_address == cotf_pkg::ADDR_ALU)
    begin
      accum_q <= sum7[7:0];
    end
    else if (run_q && clk_cnt_q == 5'h02 && (opcode_q[7:3] == 5'h1D || opcode_q[7:3] == 5'h0D))
    begin
      accum_q <= opcode_q[7] ? ram_rdata : accum_q ^ ram_rdata;
    end
    else if (wr_hit && avs_address == cotf_pkg::ADDR_OPCODE && !run_q)
    begin
      case (wbyte)
        8'hE4: accum_q <= 8'h00;
        8'hF4: accum_q <= ~accum_q;
        8'h23: accum_q <= {accum_q[6:0], accum_q[7]};
        8'h33: accum_q <= {accum_q[6:0], status_q[cotf_pkg::CY_BIT]};
        8'h03: accum_q <= {accum_q[0], accum_q[7:1]};
        8'h13: accum_q <= {status_q[cotf_pkg::CY_BIT], accum_q[7:1]};
        8'hC4: accum_q <= {accum_q[3:0], accum_q[7:4]};
        8'h64: accum_q <= accum_q ^ operand_q;
        default: accum_q <= accum_q;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      status_q <= cotf_pkg::STATUS_RESET;
    end
    else if (wr_hit && avs_address == cotf_pkg::ADDR_STATUS)
    begin
      // Software owns the user, bank and arithmetic bits; parity is not stored
      status_q <= {wbyte[7:1], 1'b0};
    end
    else if (wr_hit && avs_address == cotf_pkg::ADDR_ALU)
    begin
      status_q[cotf_pkg::CY_BIT] <= sum7[8];
      status_q[cotf_pkg::AC_BIT] <= sum4[4];
      status_q[cotf_pkg::OV_BIT] <= sum6[7] ^ sum7[8];
    end
    else if (wr_hit && avs_address == cotf_pkg::ADDR_OPCODE && !run_q)
    begin
      case (wbyte)
        8'h33: status_q[cotf_pkg::CY_BIT] <= accum_q[7];
        8'h13: status_q[cotf_pkg::CY_BIT] <= accum_q[0];
        8'hC3: status_q[cotf_pkg::CY_BIT] <= 1'b0;
        8'hD3: status_q[cotf_pkg::CY_BIT] <= 1'b1;
        8'hB3: status_q[cotf_pkg::CY_BIT] <= ~status_q[cotf_pkg::CY_BIT];
        // Boolean forms use the operand's bit 0 as the addressed bit
        8'h82: status_q[cotf_pkg::CY_BIT] <= status_q[cotf_pkg::CY_BIT] & operand_q[0];
        8'hB0: status_q[cotf_pkg::CY_BIT] <= status_q[cotf_pkg::CY_BIT] & ~operand_q[0];
        8'h72: status_q[cotf_pkg::CY_BIT] <= status_q[cotf_pkg::CY_BIT] | operand_q[0];
        8'hA0: status_q[cotf_pkg::CY_BIT] <= status_q[cotf_pkg::CY_BIT] | ~operand_q[0];
        8'hA2: status_q[cotf_pkg::CY_BIT] <= operand_q[0];
        default: status_q <= status_q;
      endcase
    end
  end

  assign status_flags = {status_q[7:1], parity};

  ////////////////////////////////////////////////////////////////////////////
  // Avalon read path: two wait cycles so the RAM read register settles

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_pend_q   <= 1'b0;
      rd_addr_q   <= 8'h00;
    end
    else
    begin
      // The done cycle blocks a restart while the master still holds read
      rd_pend_q   <= avs_read && !rd_pend_q && !rd_done_q;
      rd_addr_q   <= avs_address;
    end
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (rd_addr_q[7:5] == 3'h1 && rd_addr_q >= cotf_pkg::ADDR_RAM)
    begin
      rd_mux = {24'h000000, ram_rdata};
    end
    else
    begin
      case (rd_addr_q)
        cotf_pkg::ADDR_STATUS:  rd_mux = {24'h000000, status_flags};
        cotf_pkg::ADDR_ACCUM:   rd_mux = {24'h000000, accum_q};
        cotf_pkg::ADDR_OPCODE:  rd_mux = {24'h000000, opcode_q};
        cotf_pkg::ADDR_OPERAND: rd_mux = {24'h000000, operand_q};
        cotf_pkg::ADDR_PC:      rd_mux = {16'h0000, pc_q};
        cotf_pkg::ADDR_DECODE:  rd_mux = {16'h0000, 1'b0, clk_len_q, 1'b0,
                                  op_bytes(opcode_q), op_class(opcode_q),
                                  mcycles_q, run_q};
        cotf_pkg::ADDR_TARGET:  rd_mux = {16'h0000, target_q};
        default:                rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (rd_pend_q)
    begin
      avs_readdata <= rd_mux;
    end
  end

  // Reads stall two cycles, writes take effect at once
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rd_done_q <= 1'b0;
    end
    else
    begin
      rd_done_q <= rd_pend_q;
    end
  end

  assign avs_waitrequest = avs_read && !rd_done_q;
  assign busy            = run_q;

endmodule : cotf_core
`default_nettype wire

// file: bench/cotf_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cotf_core_monitor (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Register bus
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Status
  input wire logic        busy,
  input wire logic [7:0]  status_flags
);
  default clocking mon_cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Opcode writes while busy are dropped, so only idle launches count
  wire op_go  = avs_write && !busy && avs_address == cotf_pkg::ADDR_OPCODE;
  wire rd_end = avs_read && !avs_waitrequest;
  wire st_wr  = avs_write && !busy && avs_address == cotf_pkg::ADDR_STATUS;
  wire ac_wr  = avs_write && !busy && avs_address == cotf_pkg::ADDR_ACCUM;

  //////////////////////////////////////////////////////////////////////////////
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_read_two_waits: assert property ($rose(avs_read) |->
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait length wrong");
  a_unmapped_zero: assert property (rd_end && avs_address == 8'hFC |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_xor_reg_time: assert property (op_go && avs_writedata[7:0] == 8'h68 |=>
    busy[*8] ##1 busy[*4] ##1 !busy) else $error("short op length wrong");
  a_xor_imm_time: assert property (op_go && avs_writedata[7:0] == 8'h63 |=>
    busy[*8] ##1 busy[*8] ##1 busy[*8] ##1 !busy) else $error("long op length wrong");
  a_long_call_time: assert property (op_go && avs_writedata[7:0] == 8'h12 |=>
    busy[*8] ##1 busy[*8] ##1 busy[*8] ##1 !busy) else $error("call length wrong");
  a_abs_jump_time: assert property (op_go && avs_writedata[4:0] == 5'h01 |=>
    busy[*8] ##1 busy[*8] ##1 busy[*8] ##1 !busy) else $error("jump length wrong");
  a_clear_acc: assert property (op_go && avs_writedata[7:0] == 8'hE4 |->
    ##14 !status_flags[0]) else $error("cleared accumulator parity set");
  a_set_carry: assert property (op_go && avs_writedata[7:0] == 8'hD3 |->
    ##14 status_flags[7]) else $error("carry not set");
  a_clear_carry: assert property (op_go && avs_writedata[7:0] == 8'hC3 |->
    ##14 !status_flags[7]) else $error("carry not cleared");
  a_acc_parity: assert property (ac_wr |=>
    status_flags[0] == ^$past(avs_writedata[7:0])) else $error("parity wrong");
  a_flag_write: assert property (st_wr |=>
    status_flags[7:1] == $past(avs_writedata[7:1])) else $error("flag write lost");

  c_opcode: cover property (op_go);
  c_read: cover property (rd_end);
  c_status: cover property (st_wr);
endmodule : cotf_core_monitor

bind cotf_core cotf_core_monitor cotf_core_monitor_i (.mclk, .rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .busy, .status_flags);
`default_nettype wire

// file: bench/test_cpu_opcode_timing_flags.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_opcode_timing_flags;
  logic        mclk;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        busy;
  logic [7:0]  status_flags;
  int          fail_count;
  int          n_tests;
  int          run_n;
  int          last_run;
  logic [7:0]  rb;
  logic [15:0] rw;
  logic [7:0]  ops_long [22] = '{8'h63, 8'h43, 8'hC5, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'h92,
    8'h11, 8'hF1, 8'h01, 8'hE1, 8'h12, 8'h02, 8'h22, 8'h32, 8'h73, 8'h80, 8'h60, 8'h70,
    8'h40, 8'h50};
  logic [7:0]  ops_short [29] = '{8'h68, 8'h6F, 8'h66, 8'h67, 8'h65, 8'h64, 8'h62, 8'hE4,
    8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hE8, 8'hEF, 8'hE6, 8'hE7, 8'hC6, 8'hC7,
    8'hD6, 8'hD7, 8'hC3, 8'hD3, 8'hB3, 8'hC2, 8'hD2, 8'hB2, 8'hA2};
  // Opcode, operand bit, expected carry
  logic [23:0] cyt [8] = '{24'hD30080, 24'hB30000, 24'hA20180, 24'h820000, 24'h720180,
    24'hB00100, 24'hA00080, 24'hC30000};

  cotf_core cotf_core_i (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .busy, .status_flags);

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Length of the latest busy stretch, counted on rising edges
  always @(posedge mclk)
  begin
    if (busy === 1'b1)
      run_n <= run_n + 1;
    else if (run_n != 0)
    begin
      last_run <= run_n;
      run_n <= 0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: byte %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch at %0t: word %h expected %h", $time, g, e);
    end
  endtask : chk16

  task automatic chk_len(input int g, input int e);
    n_tests++;
    if (g != e)
    begin
      fail_count++;
      $display("mismatch at %0t: busy for %0d expected %0d", $time, g, e);
    end
  endtask : chk_len

  // Waitrequest and read data are taken at the edge, before it updates them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    avs_address <= a;
    avs_read    <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    rb = avs_readdata[7:0];
    rw = avs_readdata[15:0];
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask : rd

  task automatic go(input logic [7:0] op);
    wr(cotf_pkg::ADDR_OPCODE, {24'h0, op});
    @(negedge mclk);
    while (busy !== 1'b0)
      @(negedge mclk);
    repeat (2) @(posedge mclk);
  endtask : go

  task automatic run(input logic [7:0] op, input int n);
    go(op);
    chk_len(last_run, n);
  endtask : run

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    stop_test();
  end

  initial
  begin
    rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    fail_count = 0;
    n_tests = 0;
    run_n = 0;
    last_run = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rd(cotf_pkg::ADDR_STATUS);
    chk8(rb, 8'h00);
    foreach (ops_long[i]) run(ops_long[i], 24);
    foreach (ops_short[i]) run(ops_short[i], 12);
    // A second opcode during a long one must not restart the count
    wr(cotf_pkg::ADDR_OPCODE, 32'h63);
    run(8'hE4, 24);
    wr(cotf_pkg::ADDR_STATUS, 32'h22);
    wr(cotf_pkg::ADDR_ACCUM, 32'h88);
    wr(cotf_pkg::ADDR_ALU, 32'h88);
    rd(cotf_pkg::ADDR_STATUS);
    chk8(rb, 8'hE7);
    rd(cotf_pkg::ADDR_ACCUM);
    chk8(rb, 8'h10);
    wr(cotf_pkg::ADDR_STATUS, 32'h00);
    wr(cotf_pkg::ADDR_ACCUM, 32'h3F);
    wr(cotf_pkg::ADDR_ALU, 32'h41);
    rd(cotf_pkg::ADDR_STATUS);
    chk8(rb, 8'h45);
    for (logic [7:0] b = 0; b < 4; b++)
    begin
      wr(cotf_pkg::ADDR_STATUS, {24'h0, b << 3});
      wr(8'h20, {24'h0, 8'h10 + b});
      wr(8'h3C, {24'h0, 8'hA0 + b});
    end
    for (logic [7:0] b = 0; b < 4; b++)
    begin
      wr(cotf_pkg::ADDR_STATUS, {24'h0, b << 3});
      rd(8'h20);
      chk8(rb, 8'h10 + b);
      go(8'hEF);
      rd(cotf_pkg::ADDR_ACCUM);
      chk8(rb, 8'hA0 + b);
      go(8'h6F);
      rd(cotf_pkg::ADDR_ACCUM);
      chk8(rb, 8'h00);
    end
    wr(cotf_pkg::ADDR_ACCUM, 32'h5A);
    wr(cotf_pkg::ADDR_OPERAND, 32'hFF);
    go(8'h64);
    rd(cotf_pkg::ADDR_ACCUM);
    chk8(rb, 8'hA5);
    foreach (cyt[i])
    begin
      wr(cotf_pkg::ADDR_OPERAND, {24'h0, cyt[i][15:8]});
      go(cyt[i][23:16]);
      rd(cotf_pkg::ADDR_STATUS);
      chk8(rb & 8'h80, cyt[i][7:0]);
    end
    wr(cotf_pkg::ADDR_PC, 32'h07FE);
    wr(cotf_pkg::ADDR_OPERAND, 32'h34);
    go(8'hF1);
    rd(cotf_pkg::ADDR_TARGET);
    chk16(rw, 16'h0F34);
    wr(cotf_pkg::ADDR_PC, 32'h1234);
    wr(cotf_pkg::ADDR_OPERAND, 32'h56);
    go(8'h01);
    rd(cotf_pkg::ADDR_TARGET);
    chk16(rw, 16'h1056);
    wr(8'hFC, 32'hFF);
    rd(8'hFC);
    chk8(rb, 8'h00);
    stop_test();
  end
endmodule : test_cpu_opcode_timing_flags
`default_nettype wire
